// ### drc_asserts.sv
`timescale 1ns/1ps
module drc_checker (
  input logic        CLK_I,
  input logic        SRST_I,
  input logic        PSEL_I,
  input logic        PENABLE_I,
  input logic        PWRITE_I,
  input logic [7:0]  PADDR_I,
  input logic        PREADY_O,
  input logic [31:0] PRDATA_O,
  input logic        PSLVERR_O,
  input logic        SAMPLE_VALID_I,
  input logic        AUDIO_VALID_O,
  input logic [31:0] CH1_O,
  input logic [31:0] GAIN_A_O,
  input logic [31:0] GAIN_B_O
);
  // unmapped: past the status words or not word aligned
  wire bad = (PADDR_I[6:2] > 5'd19) || (PADDR_I[1:0] != 2'b00);
  wire acc = PSEL_I && PENABLE_I;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  a_zero_wait: assert property (PSEL_I |-> PREADY_O) else $error("ready low");
  a_out_pulse: assert property (SAMPLE_VALID_I |=> AUDIO_VALID_O) else $error("no out");
  a_out_cause: assert property (AUDIO_VALID_O |-> $past(SAMPLE_VALID_I))
    else $error("stray out");
  a_out_hold: assert property (!AUDIO_VALID_O |-> $stable(CH1_O))
    else $error("ch1 moved");
  a_gain_reset: assert property (disable iff (1'b0) SRST_I |=>
    GAIN_A_O == 32'h00800000 && GAIN_B_O == 32'h00800000) else $error("gain not unity");
  a_gain_per_sample: assert property ($changed(GAIN_A_O) || $changed(GAIN_B_O)
    |-> $past(SAMPLE_VALID_I, 3)) else $error("gain moved alone");
  a_err_unmapped: assert property (acc && bad |-> PSLVERR_O) else $error("no error");
  a_err_mapped: assert property (acc && !bad |-> !PSLVERR_O) else $error("false error");
  a_err_rd_zero: assert property (acc && bad && !PWRITE_I |-> PRDATA_O == 32'h0)
    else $error("unmapped data");
endmodule // drc_checker
bind dynamic_range_control drc_checker u_drc_checker (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .AUDIO_VALID_O(AUDIO_VALID_O), .CH1_O(CH1_O),
  .GAIN_A_O(GAIN_A_O), .GAIN_B_O(GAIN_B_O));

// ### drc_map.vh
// What this block does
// - engine chains rms, gain, smoothing stages
// - dual channel engine forwards larger rms estimate
// - one energy coefficient pair sets rms window
// - log level, region pick, seven parameter gain
// - decay for increases, attack for reductions
// - programmable input mixers scale engine inputs
// - thresholds split high, mid, low regions
// - zero offset at upper threshold gives unity
// - slopes chosen per region, low from offset
// - curve continuous at upper threshold pivot
// - curve forced to lower offset at threshold
// - thresholds are 48-bit 25.23 log values
// - offsets are 48-bit 25.23 biased log values
// - negative offset boosts, positive offset cuts
// - slope zero means unity one to one
// - slopes down to about minus sixteen accepted
// - slope below minus one gives falling output
// - smoothed gain multiplies audio in mixer
// - slopes are 28-bit 5.23 values
// - second engine serves last channel alone
`ifndef DRC_MAP_VH
`define DRC_MAP_VH
// word indices inside one engine's bank, byte address is four times the index, plus 128 when address bit 7 selects the second engine
`define IDX_LTH_LO    5'd0
`define IDX_LTH_HI    5'd1
`define IDX_UTH_LO    5'd2
`define IDX_UTH_HI    5'd3
`define IDX_LOFS_LO   5'd4
`define IDX_LOFS_HI   5'd5
`define IDX_UOFS_LO   5'd6
`define IDX_UOFS_HI   5'd7
`define IDX_LSLOPE    5'd8
`define IDX_MSLOPE    5'd9
`define IDX_HSLOPE    5'd10
`define IDX_ENERGY    5'd11
`define IDX_ENERGY_C  5'd12
`define IDX_ATTACK    5'd13
`define IDX_ATTACK_C  5'd14
`define IDX_DECAY     5'd15
`define IDX_DECAY_C   5'd16
`define IDX_MIX_GAIN  5'd17
`define IDX_GAIN_ST   5'd18
`define IDX_LEVEL_ST  5'd19
`define NUM_WR        5'd18
`define NUM_IDX       5'd20
`define ENG_SEL_BIT   7
// reset values
`define RST_LTH       32'h05000000
`define RST_UTH       32'h01000000
`define RST_OFS       32'h02000000
`define RST_COEF      32'h0000883f
`define RST_COEF_C    32'h007f77c0
`define RST_DECAY     32'h000000ae
`define RST_DECAY_C   32'h007fff51
`define RST_UNITY     32'h00800000
// log domain constants, 25.23, then the 5.23 gain ceiling
`define LOG_FS        48'h00001f000000
`define LOG_UNITY     48'h000002000000
`define LVL_MAX       48'h000020000000
`define GAIN_SAT      32'h07ffffff
`endif

// ### drc_partner.sv
`timescale 1ns/1ps
module drc_partner (
  input  logic        clk_i,
  input  logic        req_i,
  input  logic [95:0] d_i,
  output logic        vld_o,
  output logic [95:0] ch_o,
  input  logic        ovld_i,
  input  logic [95:0] o_i,
  output logic [95:0] got_o
);
  // source side: outside a sample the lines show the inverse, never the last value
  always @(posedge clk_i) begin
    vld_o <= req_i;
    ch_o <= req_i ? d_i : ~d_i;
    if (ovld_i) begin
      got_o <= o_i;
    end
  end
endmodule // drc_partner

// ### dynamic_range_control.v
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "drc_map.vh"
module dynamic_range_control (
  input  wire        CLK_I,
  input  wire        SRST_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output wire        PREADY_O,
  output reg  [31:0] PRDATA_O,
  output reg         PSLVERR_O,
  input  wire        SAMPLE_VALID_I,
  input  wire [31:0] CH1_I,
  input  wire [31:0] CH2_I,
  input  wire [31:0] CH3_I,
  output reg         AUDIO_VALID_O,
  output reg  [31:0] CH1_O,
  output reg  [31:0] CH2_O,
  output reg  [31:0] CH3_O,
  output reg  [31:0] GAIN_A_O,
  output reg  [31:0] GAIN_B_O
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage, two banks of writable words
  reg  [31:0] cfg [0:35];
  reg  [63:0] e1_r;
  reg  [63:0] e2_r;
  reg  [63:0] e3_r;
  reg  [47:0] lvl_a_r;
  reg  [47:0] lvl_b_r;
  reg  [31:0] tgt_a_r;
  reg  [31:0] tgt_b_r;
  reg  [31:0] gain_a_r;
  reg  [31:0] gain_b_r;
  reg         v1_r;
  reg         v2_r;
  integer     k;

  wire        eng     = PADDR_I[`ENG_SEL_BIT];
  wire [4:0]  idx     = PADDR_I[6:2];
  wire        mapped  = (PADDR_I[1:0] == 2'b00) && (idx < `NUM_IDX);
  wire        wr_ok   = mapped && (idx < `NUM_WR);
  wire [5:0]  widx    = (eng ? 6'd18 : 6'd0) + {1'b0, idx};
  wire        setup   = PSEL_I && !PENABLE_I;
  wire        access  = PSEL_I && PENABLE_I;

  // zero wait states: read data is latched in the setup cycle
  assign PREADY_O = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function [31:0] rst_val;
    input [4:0] i;
    begin
      case (i)
        `IDX_LTH_LO:   rst_val = `RST_LTH;
        `IDX_UTH_LO:   rst_val = `RST_UTH;
        `IDX_LOFS_LO:  rst_val = `RST_OFS;
        `IDX_UOFS_LO:  rst_val = `RST_OFS;
        `IDX_ENERGY:   rst_val = `RST_COEF;
        `IDX_ENERGY_C: rst_val = `RST_COEF_C;
        `IDX_ATTACK:   rst_val = `RST_COEF;
        `IDX_ATTACK_C: rst_val = `RST_COEF_C;
        `IDX_DECAY:    rst_val = `RST_DECAY;
        `IDX_DECAY_C:  rst_val = `RST_DECAY_C;
        `IDX_MIX_GAIN: rst_val = `RST_UNITY;
        default:       rst_val = 32'h00000000;
      endcase
    end
  endfunction

  // 48-bit 25.23 word from a low/high pair of one bank
  function [47:0] p48;
    input       b;
    input [4:0] i;
    reg   [5:0] a;
    begin
      a   = (b ? 6'd18 : 6'd0) + {1'b0, i};
      p48 = {cfg[a + 6'd1][15:0], cfg[a]};
    end
  endfunction

  function [31:0] pw;
    input       b;
    input [4:0] i;
    begin
      pw = cfg[(b ? 6'd18 : 6'd0) + {1'b0, i}];
    end
  endfunction

  // slope word cut to its 28 signed bits, upper bits are don't care
  function [27:0] slope_of;
    input       b;
    input [4:0] i;
    reg  [31:0] w;
    begin
      w        = pw(b, i);
      slope_of = w[27:0];
    end
  endfunction

  // signed 5.23 scaling with saturation to 32 bits
  function [31:0] scale;
    input [31:0] x;
    input [31:0] g;
    reg signed [63:0] p;
    begin
      p = ($signed(x) * $signed(g)) >>> 23;
      if (p > 64'sh000000007fffffff)
        scale = 32'h7fffffff;
      else if (p < -64'sh0000000080000000)
        scale = 32'h80000000;
      else
        scale = p[31:0];
    end
  endfunction

  // mean square update, energy and its complement share one window
  function [63:0] energy;
    input [63:0] e;
    input [31:0] x;
    input [31:0] ca;
    input [31:0] cc;
    reg signed [63:0] sq;
    reg        [96:0] p;
    begin
      sq     = $signed(x) * $signed(x);
      p      = {65'h0, ca} * {33'h0, sq} + {65'h0, cc} * {33'h0, e};
      energy = p[86:23];
    end
  endfunction

  // rms level below full scale in 25.23, positive means quieter
  function [47:0] level;
    input [63:0] e;
    integer     i;
    reg   [5:0] m;
    reg  [63:0] s;
    reg  [47:0] l2;
    begin
      m = 6'd0;
      for (i = 0; i < 64; i = i + 1) begin
        if (e[i])
          m = i[5:0];
      end
      s  = e << (6'd63 - m);
      l2 = {19'h0, m, s[62:40]};
      // half the log of the square gives the log of the rms value
      if (e == 64'h0)
        level = `LVL_MAX;
      else
        level = $signed(`LOG_FS - l2) >>> 1;
    end
  endfunction

  // region pick and cut in log units, cut is positive for attenuation
  function [47:0] cut_of;
    input        b;
    input [47:0] l;
    reg signed [47:0] t1;
    reg signed [47:0] t2;
    reg signed [47:0] d;
    reg signed [47:0] o;
    reg signed [27:0] s;
    reg signed [75:0] p;
    begin
      t1 = p48(b, `IDX_LTH_LO);
      t2 = p48(b, `IDX_UTH_LO);
      if ($signed(l) < t2) begin // high region
        s = slope_of(b, `IDX_HSLOPE);
        d = t2 - $signed(l);
        o = p48(b, `IDX_UOFS_LO);
      end else if ($signed(l) < t1) begin // mid region shares the pivot
        s = slope_of(b, `IDX_MSLOPE);
        d = t2 - $signed(l);
        o = p48(b, `IDX_UOFS_LO);
      end else begin // low region snaps to lower_offset
        s = slope_of(b, `IDX_LSLOPE);
        d = t1 - $signed(l);
        o = p48(b, `IDX_LOFS_LO);
      end
      // full signed slope range, below -1 the output falls
      p      = s * d;
      cut_of = o - p[70:23];
    end
  endfunction

  // linear 5.23 gain from cut, zero dB offset maps to unity
  function [31:0] coef_of;
    input [47:0] c;
    reg signed [47:0] e;
    reg signed [24:0] n;
    reg        [31:0] m;
    begin
      e = `LOG_UNITY - c;
      n = e[47:23];
      m = {8'h00, 1'b1, e[22:0]};
      if (e >= $signed(`LOG_UNITY))
        coef_of = `GAIN_SAT; // 5.23 tops out just below sixteen
      else if (n < -25'sd23)
        coef_of = 32'h00000000;
      else if (n >= 0)
        coef_of = m << n[4:0];
      else
        coef_of = m >> (-n);
    end
  endfunction

  // one pole smoothing, attack when gain falls, decay when it rises
  function [31:0] smooth;
    input        b;
    input [31:0] g;
    input [31:0] t;
    reg   [31:0] c;
    reg   [31:0] cc;
    reg   [64:0] p;
    begin
      c  = (t < g) ? pw(b, `IDX_ATTACK) : pw(b, `IDX_DECAY);
      cc = (t < g) ? pw(b, `IDX_ATTACK_C) : pw(b, `IDX_DECAY_C);
      p  = {33'h0, c} * {33'h0, t} + {33'h0, cc} * {33'h0, g};
      smooth = p[54:23];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: write at the access edge, read data latched at setup
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      for (k = 0; k < 36; k = k + 1)
        cfg[k] <= rst_val((k < 18) ? k[4:0] : k[4:0] - 5'd18);
      PRDATA_O  <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else begin
      if (setup) begin
        PSLVERR_O <= !mapped;
        if (!mapped || PWRITE_I)
          PRDATA_O <= 32'h00000000;
        else if (idx == `IDX_GAIN_ST)
          PRDATA_O <= eng ? gain_b_r : gain_a_r;
        else if (idx == `IDX_LEVEL_ST)
          PRDATA_O <= eng ? lvl_b_r[31:0] : lvl_a_r[31:0];
        else
          PRDATA_O <= cfg[widx];
      end
      // status words ignore writes, unmapped ones flag an error
      if (access && PWRITE_I && wr_ok)
        cfg[widx] <= PWDATA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage one: input mixers and rms estimators
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      e1_r <= 64'h0;
      e2_r <= 64'h0;
      e3_r <= 64'h0;
      v1_r <= 1'b0;
    end else begin
      v1_r <= SAMPLE_VALID_I;
      if (SAMPLE_VALID_I) begin
        e1_r <= energy(e1_r, scale(CH1_I, pw(1'b0, `IDX_MIX_GAIN)),
                       pw(1'b0, `IDX_ENERGY), pw(1'b0, `IDX_ENERGY_C));
        e2_r <= energy(e2_r, scale(CH2_I, pw(1'b0, `IDX_MIX_GAIN)),
                       pw(1'b0, `IDX_ENERGY), pw(1'b0, `IDX_ENERGY_C));
        e3_r <= energy(e3_r, scale(CH3_I, pw(1'b1, `IDX_MIX_GAIN)),
                       pw(1'b1, `IDX_ENERGY), pw(1'b1, `IDX_ENERGY_C));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage two: larger estimate, log level and target gain
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      lvl_a_r <= `LVL_MAX;
      lvl_b_r <= `LVL_MAX;
      tgt_a_r <= `RST_UNITY;
      tgt_b_r <= `RST_UNITY;
      v2_r    <= 1'b0;
    end else begin
      v2_r <= v1_r;
      if (v1_r) begin
        lvl_a_r <= level((e1_r > e2_r) ? e1_r : e2_r);
        lvl_b_r <= level(e3_r);
        tgt_a_r <= coef_of(cut_of(1'b0, level((e1_r > e2_r) ? e1_r : e2_r)));
        tgt_b_r <= coef_of(cut_of(1'b1, level(e3_r)));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage three: attack/decay smoothing, one step per sample
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      gain_a_r <= `RST_UNITY;
      gain_b_r <= `RST_UNITY;
      GAIN_A_O <= `RST_UNITY;
      GAIN_B_O <= `RST_UNITY;
    end else if (v2_r) begin
      gain_a_r <= smooth(1'b0, gain_a_r, tgt_a_r);
      gain_b_r <= smooth(1'b1, gain_b_r, tgt_b_r);
      GAIN_A_O <= smooth(1'b0, gain_a_r, tgt_a_r);
      GAIN_B_O <= smooth(1'b1, gain_b_r, tgt_b_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain mixer: the sample uses the gain settled from earlier samples,
  // trading one sample of lag for a short combinational path
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      AUDIO_VALID_O <= 1'b0;
      CH1_O         <= 32'h00000000;
      CH2_O         <= 32'h00000000;
      CH3_O         <= 32'h00000000;
    end else begin
      AUDIO_VALID_O <= SAMPLE_VALID_I;
      if (SAMPLE_VALID_I) begin
        CH1_O <= scale(CH1_I, gain_a_r);
        CH2_O <= scale(CH2_I, gain_a_r);
        CH3_O <= scale(CH3_I, gain_b_r);
      end
    end
  end

endmodule // dynamic_range_control

// ### tb_top.sv
`timescale 1ns/1ps
`include "drc_map.vh"
module tb_top;
  logic        CLK_I, SRST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O;
  logic        SAMPLE_VALID_I, AUDIO_VALID_O, req, er;
  logic [7:0]  PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, CH1_I, CH2_I, CH3_I, CH1_O, CH2_O, CH3_O;
  logic [31:0] GAIN_A_O, GAIN_B_O, d1, d2, d3, g1, g2, g3, rd, v;
  int          mismatches, n_compared, i, b;
  // ch1, ch2, engine input gain, expected gain
  logic [31:0] tab [5][4] = '{'{32'hc0000000, 0, `RST_UNITY, 32'h00080000},
    '{32'h04000000, 32'h10000000, `RST_UNITY, 32'h00400000},
    '{32'h00100000, 0, `RST_UNITY, 32'h01000000},
    '{32'h20000000, 0, 32'h01000000, 32'h00080000},
    '{32'h20000000, 0, `RST_UNITY, `RST_UNITY}};
  dynamic_range_control u_dynamic_range_control (.CLK_I(CLK_I), .SRST_I(SRST_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
    .SAMPLE_VALID_I(SAMPLE_VALID_I), .CH1_I(CH1_I), .CH2_I(CH2_I), .CH3_I(CH3_I),
    .AUDIO_VALID_O(AUDIO_VALID_O), .CH1_O(CH1_O), .CH2_O(CH2_O), .CH3_O(CH3_O),
    .GAIN_A_O(GAIN_A_O), .GAIN_B_O(GAIN_B_O));
  drc_partner u_drc_partner (.clk_i(CLK_I), .req_i(req), .d_i({d1, d2, d3}),
    .vld_o(SAMPLE_VALID_I), .ch_o({CH1_I, CH2_I, CH3_I}), .ovld_i(AUDIO_VALID_O),
    .o_i({CH1_O, CH2_O, CH3_O}), .got_o({g1, g2, g3}));
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // mixer product in 5.23, gain unsigned
  function automatic logic [31:0] mix(input logic [31:0] a, input logic [31:0] g);
    logic signed [63:0] p;
    p = $signed(a) * $signed({1'b0, g});
    mix = p[54:23];
  endfunction
  function automatic logic [31:0] dflt(input int k);
    case (k)
      0: dflt = `RST_LTH;
      2: dflt = `RST_UTH;
      4, 6: dflt = `RST_OFS;
      11, 13: dflt = `RST_COEF;
      12, 14: dflt = `RST_COEF_C;
      15: dflt = `RST_DECAY;
      16: dflt = `RST_DECAY_C;
      17, 18: dflt = `RST_UNITY;
      default: dflt = 32'h0;
    endcase
  endfunction
  // one transfer; a spare edge after release keeps strobes single-driven
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 20);
    if (PREADY_O !== 1'b1) begin
      mismatches++;
      report_and_stop;
    end
    rd = PRDATA_O;
    er = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task automatic send(input logic [31:0] a1, input logic [31:0] a2);
    req <= 1'b1;
    d1 <= a1;
    d2 <= a2;
    d3 <= $urandom;
    @(posedge CLK_I);
    req <= 1'b0;
    repeat (8) @(posedge CLK_I);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  initial begin
    void'($urandom(92176));
    {SRST_I, PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} = {1'b1, 43'h0};
    {req, d1, d2, d3} = 97'h0;
    repeat (16) @(posedge CLK_I);
    SRST_I <= 1'b0;
    @(posedge CLK_I);
    chk(GAIN_A_O, `RST_UNITY);
    for (i = 0; i < 19; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, dflt(i));
    end
    // status word is read only, unmapped places answer with an error
    apb(1'b1, 8'hc8, 32'h0);
    apb(1'b0, 8'hc8, 32'h0);
    chk(rd, `RST_UNITY);
    apb(1'b0, 8'h50, 32'h0);
    chk({er, rd}, 64'h100000000);
    apb(1'b1, 8'h01, 32'h0);
    chk(er, 1'b1);
    repeat (3) begin
      v = $urandom | 32'h00000001;
      apb(1'b1, 8'h80, v);
      apb(1'b0, 8'h80, 32'h0);
      chk(rd, v);
    end
    // instant estimator and smoother so one sample settles the gain
    for (b = 0; b < 2; b++)
      for (i = 11; i < 17; i++)
        apb(1'b1, 8'(b * 128 + i * 4), i[0] ? `RST_UNITY : 32'h0);
    apb(1'b1, 8'h24, `RST_UNITY);
    apb(1'b1, 8'h28, 32'h0e000000);
    apb(1'b1, 8'h10, 32'h01800000);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, 8'h44, tab[i][2]);
      send(tab[i][0], tab[i][1]);
      send(tab[i][0], tab[i][1]);
      chk(GAIN_A_O, tab[i][3]);
      if (tab[i][2] == `RST_UNITY) chk(g1, mix(tab[i][0], tab[i][3]));
      if (tab[i][2] == `RST_UNITY) chk(g2, mix(tab[i][1], tab[i][3]));
      chk(g3, d3);
      chk(GAIN_B_O, `RST_UNITY);
    end
    // level status: a sample two bits below full scale reads 2.0
    apb(1'b0, 8'h4c, 32'h0);
    chk(rd, 32'h01000000);
    // attack one half, decay one quarter
    apb(1'b1, 8'h34, 32'h00400000);
    apb(1'b1, 8'h38, 32'h00400000);
    apb(1'b1, 8'h3c, 32'h00200000);
    apb(1'b1, 8'h40, 32'h00600000);
    send(32'h40000000, 32'h0);
    chk(GAIN_A_O, 32'h00440000);
    send(32'h20000000, 32'h0);
    chk(GAIN_A_O, 32'h00530000);
    SRST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    SRST_I <= 1'b0;
    @(posedge CLK_I);
    chk(GAIN_A_O, `RST_UNITY);
    apb(1'b0, 8'h34, 32'h0);
    chk(rd, `RST_COEF);
    report_and_stop;
  end
endmodule // tb_top
